// [rtl/spc_core.sv]
// Purpose: Serial pin routing, master framing and slave shifting.
// Assumes: Partner clock is slow enough to be sampled by clk_in.
// Notes: Registers sit on AXI4-Lite; one level interrupt.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "spc_params.svh"
module spc_core import spc_pkg::*; (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [`SPC_AW-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [`SPC_AW-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              serial_clock_pin_in,
  output logic                   serial_clock_pin_out,
  output logic                   serial_clock_pin_oe_out,
  input  wire logic              mo_pin_in,
  output logic                   mo_pin_out,
  output logic                   mo_pin_oe_out,
  input  wire logic              mi_pin_in,
  output logic                   mi_pin_out,
  output logic                   mi_pin_oe_out,
  input  wire logic              sel_pin_in,
  output logic                   sel_pin_out,
  output logic                   sel_pin_oe_out,
  output logic                   irq_out
);
  spc_ctrl_type           ctrl;
  spc_mst_type            mst_st;
  spc_pins_type           pin_out;
  spc_pins_type           pin_oe;
  spc_pins_type           next_out;
  spc_pins_type           next_oe;
  logic [`SPC_PIN_W-1:0]  pin_s;
  logic [7:0]             tx_data;
  logic [7:0]             rx_data;
  logic [7:0]             shreg;
  logic [7:0]             div_cnt;
  logic [4:0]             k;
  logic [4:0]             next_k;
  logic [1:0]             status;
  logic [1:0]             mask;
  logic [1:0]             st_set;
  logic [1:0]             st_clr;
  logic                   aw_held;
  logic                   w_held;
  logic [`SPC_AW-1:0]     aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_go;
  logic                   rd_go;
  logic [2:0]             wr_dec;
  logic [2:0]             rd_dec;
  logic [31:0]            rd_mux;
  logic                   sck_d;
  logic                   m_sck;
  logic                   m_sel;
  logic                   tick;
  logic                   m_ev;
  logic                   s_ev;
  logic                   ev;
  logic                   done_ev;
  logic                   samp;
  logic                   din;
  logic                   tbit;
  logic                   sel_s;
  logic                   fault;
  logic                   start;
  logic                   busy;
  logic                   sample_now;
  logic                   shift_now;
  logic [7:0]             fin;

  function automatic logic [7:0] f_shift(input logic [7:0] v, input logic b,
                                         input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : f_shift

  function automatic logic f_outbit(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction : f_outbit

  // Byte enables merge a write into the old value lane by lane.
  function automatic logic [31:0] f_merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : f_merge

  // Result is {hit, index}; index 0..3 follows the offset order.
  function automatic logic [2:0] f_decode(input logic [`SPC_AW-1:0] a);
    if (a == `SPC_OFS_CTRL) begin
      return 3'h4;
    end else if (a == `SPC_OFS_DATA) begin
      return 3'h5;
    end else if (a == `SPC_OFS_STAT) begin
      return 3'h6;
    end else if (a == `SPC_OFS_MASK) begin
      return 3'h7;
    end else begin
      return 3'h0;
    end
  endfunction : f_decode

  spc_sync #(.W(`SPC_PIN_W)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({sel_pin_in, mi_pin_in, mo_pin_in, serial_clock_pin_in}),
    .q_out  (pin_s)
  );

  assign sel_s  = pin_s[`SPC_PIN_SEL];
  assign wr_go  = aw_held && w_held && !s_axi_bvalid_out;
  assign rd_go  = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_dec = f_decode(aw_addr);
  assign rd_dec = f_decode(s_axi_araddr_in);
  assign start  = wr_go && wr_dec == 3'h5 && ctrl.interface_enable
                  && ctrl.master && mst_st == M_IDLE;
  // A low select while this master listens for faults means another master.
  assign fault  = ctrl.interface_enable && ctrl.master && ctrl.fault_detect_enable
                  && !ctrl.select_output_enable && !sel_s;
  assign busy   = (mst_st != M_IDLE) || (k != '0);
  assign tick   = ({1'b0, div_cnt} + 9'h001) >= {1'b0, ctrl.half_div};
  assign m_ev   = tick && (mst_st == M_LEAD || mst_st == M_SHIFT)
                  && ctrl.interface_enable && ctrl.master && !fault;
  assign s_ev   = ctrl.interface_enable && !ctrl.master && !sel_s
                  && (pin_s[`SPC_PIN_SCK] != sck_d);
  assign ev     = ctrl.master ? m_ev : s_ev;
  assign next_k = k + 5'h01;
  assign din    = (ctrl.master ^ ctrl.single_wire_select) ? pin_s[`SPC_PIN_MI]
                                                         : pin_s[`SPC_PIN_MO];
  assign tbit   = f_outbit(shreg, ctrl.bit_order_lsb_first);
  // Phase 1 samples on even edges, phase 0 on odd ones.
  assign sample_now = ctrl.cpha ? !next_k[0] : next_k[0];
  assign shift_now  = ctrl.cpha ? (next_k[0] && next_k != 5'h01) : !next_k[0];
  assign done_ev    = ev && next_k == `SPC_EDGES;
  assign fin        = f_shift(shreg, ctrl.cpha ? din : samp, ctrl.bit_order_lsb_first);

  // AXI write channel: address and data are taken in either order.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= '0;
      w_data            <= '0;
      w_strb            <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `SPC_RESP_OK;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held           <= 1'b1;
        aw_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held           <= 1'b1;
        w_data           <= s_axi_wdata_in;
        w_strb           <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end else if (!w_held && !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'b1;
      end
      if (wr_go) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_dec[2] ? `SPC_RESP_OK : `SPC_RESP_ERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Control, transmit data and mask registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl    <= spc_ctrl_type'(`SPC_CTRL_RST);
      tx_data <= '0;
      mask    <= '0;
    end else begin
      if (wr_go && wr_dec == 3'h4) begin
        ctrl <= spc_ctrl_type'(17'(f_merge(32'(ctrl), w_data, w_strb)));
      end
      if (wr_go && wr_dec == 3'h5) begin
        tx_data <= 8'(f_merge(32'(tx_data), w_data, w_strb));
      end
      if (wr_go && wr_dec == 3'h7) begin
        mask <= 2'(f_merge(32'(mask), w_data, w_strb));
      end
      // A mode fault drops the interface so two masters never fight.
      if (fault) begin
        ctrl.interface_enable <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    if (rd_dec == 3'h4) begin
      rd_mux = 32'(ctrl);
    end else if (rd_dec == 3'h5) begin
      rd_mux = 32'(rx_data);
    end else if (rd_dec == 3'h6) begin
      rd_mux = 32'({busy, status});
    end else if (rd_dec == 3'h7) begin
      rd_mux = 32'(mask);
    end
  end

  // AXI read channel; a status read clears the sticky bits.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= `SPC_RESP_OK;
    end else if (rd_go) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_mux;
      s_axi_rresp_out   <= rd_dec[2] ? `SPC_RESP_OK : `SPC_RESP_ERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end else if (!s_axi_rvalid_out) begin
      s_axi_arready_out <= 1'b1;
    end
  end

  assign st_set = {fault, done_ev};
  assign st_clr = (rd_go && rd_dec == 3'h6) ? 2'h3 : 2'h0;

  // A new event beats a clearing read in the same cycle.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status  <= '0;
      irq_out <= 1'b0;
    end else begin
      status  <= (status & ~st_clr) | st_set;
      irq_out <= |(status & mask);
    end
  end

  // Master framing: lead half period, sixteen edges, trailing half period.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mst_st  <= M_IDLE;
      div_cnt <= '0;
      m_sck   <= 1'b0;
      m_sel   <= 1'b1;
    end else if (fault || !ctrl.interface_enable || !ctrl.master) begin
      mst_st  <= M_IDLE;
      div_cnt <= '0;
      m_sck   <= ctrl.cpol;
      m_sel   <= 1'b1;
    end else begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      case (mst_st)
        M_IDLE: begin
          m_sck   <= ctrl.cpol;
          div_cnt <= '0;
          if (start) begin
            mst_st <= M_LEAD;
            m_sel  <= 1'b0;
          end
        end
        M_LEAD: begin
          if (tick) begin
            m_sck  <= ~m_sck;
            mst_st <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (tick) begin
            m_sck <= ~m_sck;
            if (k == `SPC_LAST_EDGE) begin
              mst_st <= M_TRAIL;
              m_sel  <= 1'b1;
            end
          end
        end
        M_TRAIL: begin
          if (tick) begin
            mst_st <= M_IDLE;
          end
        end
        default: begin
          mst_st <= M_IDLE;
        end
      endcase
    end
  end

  // Shared shifter; the slave reloads whenever it is not selected.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shreg   <= '0;
      k       <= '0;
      samp    <= 1'b0;
      rx_data <= '0;
      sck_d   <= 1'b0;
    end else begin
      sck_d <= pin_s[`SPC_PIN_SCK];
      if (start) begin
        shreg <= w_data[7:0];
        k     <= '0;
      end else if (!ctrl.master && (sel_s || !ctrl.interface_enable)) begin
        shreg <= tx_data;
        k     <= '0;
      end else if (ctrl.master && mst_st == M_IDLE) begin
        k <= '0;
      end else if (done_ev) begin
        rx_data <= fin;
        k       <= '0;
        // A master holds its output bit through the last edge, which a phase 1 slave samples.
        shreg   <= ctrl.master ? shreg : tx_data;
      end else if (ev) begin
        k <= next_k;
        if (sample_now) begin
          samp <= din;
        end
        if (shift_now) begin
          shreg <= f_shift(shreg, samp, ctrl.bit_order_lsb_first);
        end
      end
    end
  end

  // Pin routing; all drive is registered so pins come straight from flops.
  always_comb begin
    next_out = '0;
    next_oe  = '0;
    if (ctrl.interface_enable) begin
      next_oe.sck  = ctrl.master;
      next_out.sck = m_sck;
      if (!ctrl.single_wire_select) begin
        next_oe.mo  = ctrl.master;
        next_out.mo = tbit;
        next_oe.mi  = !ctrl.master && !sel_s;
        next_out.mi = tbit;
      end else if (ctrl.master) begin
        next_oe.mo  = ctrl.bidir_direction_out;
        next_out.mo = tbit;
      end else begin
        next_oe.mi  = ctrl.bidir_direction_out;
        next_out.mi = tbit;
      end
      if (ctrl.master && ctrl.fault_detect_enable && ctrl.select_output_enable) begin
        next_oe.sel  = 1'b1;
        next_out.sel = m_sel;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  assign serial_clock_pin_out    = pin_out.sck;
  assign serial_clock_pin_oe_out = pin_oe.sck;
  assign mo_pin_out              = pin_out.mo;
  assign mo_pin_oe_out           = pin_oe.mo;
  assign mi_pin_out              = pin_out.mi;
  assign mi_pin_oe_out           = pin_oe.mi;
  assign sel_pin_out             = pin_out.sel;
  assign sel_pin_oe_out          = pin_oe.sel;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_slave_sel_fall;
    ctrl.interface_enable && !ctrl.master && !ctrl.cpha && $fell(sel_s);
  endsequence

  sequence s_held(logic c);
    c ##1 (c && $stable(ctrl));
  endsequence

  a_off_release: assert property (s_held(!ctrl.interface_enable) |=>
    !(pin_oe.sck || pin_oe.mo || pin_oe.mi || pin_oe.sel))
    else $error("Pins driven while interface disabled.");
  a_sck_dir: assert property (s_held(ctrl.interface_enable) |=>
    pin_oe.sck == $past(ctrl.master))
    else $error("Clock pin direction wrong.");
  a_mo_normal: assert property (s_held(ctrl.interface_enable
    && !ctrl.single_wire_select) |=> pin_oe.mo == $past(ctrl.master))
    else $error("Master-out pin direction wrong.");
  a_shared_dir: assert property (s_held(ctrl.interface_enable
    && ctrl.single_wire_select) |=> ($past(ctrl.master) ? pin_oe.mo : pin_oe.mi)
    == $past(ctrl.bidir_direction_out)
    && !($past(ctrl.master) ? pin_oe.mi : pin_oe.mo))
    else $error("Shared data line direction wrong.");
  a_sel_use: assert property (s_held(ctrl.interface_enable
    && ctrl.master) |=> pin_oe.sel == $past(ctrl.fault_detect_enable
    && ctrl.select_output_enable))
    else $error("Select pin use wrong.");
  a_ss_frame: assert property (start ##1 (mst_st == M_LEAD) |->
    !m_sel ##1 (!m_sel [*2]))
    else $error("Select output not low through frame start.");
  a_done_edges: assert property (done_ev && ctrl.master |=>
    m_sel && mst_st == M_TRAIL)
    else $error("Master frame did not end at edge sixteen.");
  a_cpha1_samp: assert property (ev && ctrl.cpha && sample_now && !done_ev
    |=> samp == $past(din))
    else $error("Phase 1 sample missed.");
  a_b2b_reload: assert property (done_ev && !ctrl.master |=>
    k == '0 && shreg == $past(tx_data))
    else $error("Slave not ready for next transfer.");
  a_first_bit: assert property (s_slave_sel_fall ##0 $stable(tx_data) |=>
    ##1 pin_out.mi == f_outbit($past(tx_data, 2), ctrl.bit_order_lsb_first))
    else $error("First slave bit not presented on select.");
endmodule : spc_core

// [rtl/spc_params.svh]
// Purpose: Constants for the serial pin control and framing block.
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data.
// Notes: Function
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_AW 8
`define SPC_OFS_CTRL 8'h00
`define SPC_OFS_DATA 8'h04
`define SPC_OFS_STAT 8'h08
`define SPC_OFS_MASK 8'h0C
`define SPC_CTRL_RST 17'h0_1000
`define SPC_ST_DONE 0
`define SPC_ST_FAULT 1
`define SPC_LAST_EDGE 5'h0F
`define SPC_EDGES 5'h10
`define SPC_RESP_OK 2'h0
`define SPC_RESP_ERR 2'h2
`define SPC_PIN_W 4
`define SPC_PIN_SCK 0
`define SPC_PIN_MO 1
`define SPC_PIN_MI 2
`define SPC_PIN_SEL 3
`endif

// [rtl/spc_pkg.sv]
// Purpose: Types shared by the serial pin control block.
// Assumes: Field order matches the control register layout, bit 0 last.
// Notes: Pin vectors put the clock pin at bit 0.
package spc_pkg;
  typedef struct packed {
    logic [7:0] half_div;
    logic       select_output_enable;
    logic       fault_detect_enable;
    logic       bidir_direction_out;
    logic       single_wire_select;
    logic       bit_order_lsb_first;
    logic       cpha;
    logic       cpol;
    logic       master;
    logic       interface_enable;
  } spc_ctrl_type;

  typedef struct packed {
    logic sel;
    logic mi;
    logic mo;
    logic sck;
  } spc_pins_type;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_LEAD  = 2'b01,
    M_SHIFT = 2'b10,
    M_TRAIL = 2'b11
  } spc_mst_type;
endpackage : spc_pkg

// [rtl/spc_sync.sv]
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes: The first stage is read only by the second.
module spc_sync import spc_pkg::*; #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : spc_sync

// [verification/spc_pin_control_and_framing_test.sv]
// Purpose: Self-checking bench for the serial pin control block.
// Assumes: The bench plays the external master; the partner model plays the slave.
// Notes: Master-in has a pull-up; the bench drives the other lines when they are released.
`include "spc_params.svh"
module spc_pin_control_and_framing_test import spc_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'h0, rst_in = 1'h1;
  logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00, reply = 8'h00;
  logic [31:0] w_data = 32'h0000_0000;
  logic        aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0, ar_valid = 1'h0, r_ready = 1'h0;
  logic        m_sck = 1'h0, m_mo = 1'h0, m_sel = 1'h1, p_cpha = 1'h0, p_lsb = 1'h0;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, irq;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_data;
  logic        sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, sel_o, sel_oe, p_mi, p_mi_oe;
  logic [7:0]  p_got;
  int          lead;
  int          n_fail = 0, compares = 0, seed = 7;
  wire         sck_w = sck_oe ? sck_o : m_sck;
  wire         mo_w = mo_oe ? mo_o : m_mo;
  wire         mi_w = mi_oe ? mi_o : (p_mi_oe ? p_mi : 1'h1);
  wire         sel_w = sel_oe ? sel_o : m_sel;
  wire         p_sel = sel_oe ? sel_o : 1'h1;
  wire [3:0]   oe_v = {sel_oe, mi_oe, mo_oe, sck_oe};

  always #5 clk_in = ~clk_in;

  spc_core u_spc_core (
    .clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready),
    .s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_valid),
    .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid),
    .s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
    .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
    .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe_out(sck_oe), .mo_pin_in(mo_w), .mo_pin_out(mo_o),
    .mo_pin_oe_out(mo_oe), .mi_pin_in(mi_w), .mi_pin_out(mi_o), .mi_pin_oe_out(mi_oe),
    .sel_pin_in(sel_w), .sel_pin_out(sel_o), .sel_pin_oe_out(sel_oe), .irq_out(irq)
  );
  spc_slave_model u_spc_slave_model (
    .sck_in(sck_w), .sel_n_in(p_sel), .cpha_in(p_cpha), .lsb_in(p_lsb), .mosi_in(mo_w),
    .reply_in(reply), .miso_out(p_mi), .miso_oe_out(p_mi_oe), .got_out(p_got), .lead_out(lead)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    aw_addr  <= a;
    w_data   <= d;
    aw_valid <= 1'h1;
    w_valid  <= 1'h1;
    b_ready  <= 1'h1;
    fork
      begin
        do @(posedge clk_in); while (!aw_ready);
        aw_valid <= 1'h0;
      end
      begin
        do @(posedge clk_in); while (!w_ready);
        w_valid <= 1'h0;
      end
    join
    do @(posedge clk_in); while (!b_valid);
    r = b_resp;
    b_ready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    ar_addr  <= a;
    ar_valid <= 1'h1;
    r_ready  <= 1'h1;
    do @(posedge clk_in); while (!ar_ready);
    ar_valid <= 1'h0;
    do @(posedge clk_in); while (!r_valid);
    d = r_data;
    r = r_resp;
    r_ready <= 1'h0;
  endtask : rd

  // Bench as external master, clock polarity 0, most significant bit first, 125 ns period.
  task automatic slv(input logic [7:0] t, input logic c1, output logic [7:0] g);
    for (int i = 7; i >= 0; i--) begin
      if (!c1) m_mo <= t[i];
      #62.5 m_sck <= 1'h1;
      if (c1) m_mo <= t[i];
      else g = {g[6:0], mi_w};
      #62.5 m_sck <= 1'h0;
      if (c1) g = {g[6:0], mi_w};
    end
    #62.5;
  endtask : slv

  // Order is select, master-in, master-out, clock; idle, with select high.
  function automatic logic [3:0] exp_oe(input logic [16:0] c);
    if (!c[0]) return 4'h0;
    if (c[1]) return {c[7] & c[8], 1'h0, c[5] ? c[6] : 1'h1, 1'h1};
    return {1'h0, c[5] & c[6], 2'h0};
  endfunction : exp_oe

  initial begin : main
    logic [1:0]  r;
    logic [31:0] d;
    logic [16:0] c;
    logic [7:0]  tx;
    logic [7:0]  a;
    logic [7:0]  g;
    logic [7:0]  g2;
    logic        mk;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'h0;
    rd(`SPC_OFS_CTRL, d, r);
    chk("ctrl reset", 32'h0000_1000, d);
    chk("pins after reset", 4'h0, oe_v);
    rd(8'h10, d, r);
    chk("unmapped read", `SPC_RESP_ERR, r);
    wr(8'h10, 32'h0000_0001, r);
    chk("unmapped write", `SPC_RESP_ERR, r);
    for (int i = 0; i < 40; i++) begin
      c = {8'h08, 9'($random(seed))};
      wr(`SPC_OFS_CTRL, {15'h0, c}, r);
      repeat (3) @(posedge clk_in);
      chk("pin enables", exp_oe(c), oe_v);
      if (c[1:0] == 2'h3) chk("clock idle", c[2], sck_o);
    end
    for (int i = 0; i < 4; i++) begin
      tx = 8'($random(seed));
      a = 8'($random(seed));
      mk = 1'($random(seed));
      reply <= a;
      p_cpha <= i[0];
      p_lsb <= i[1];
      wr(`SPC_OFS_MASK, {31'h0, mk}, r);
      c = {8'h08, 4'hC, i[1], i[0], 1'($random(seed)), 2'h3};
      wr(`SPC_OFS_CTRL, {15'h0, c}, r);
      wr(`SPC_OFS_DATA, {24'h0, tx}, r);
      wait (sel_w === 1'h0);
      wait (sel_w === 1'h1);
      repeat (4) @(posedge clk_in);
      chk("irq level", mk, irq);
      rd(`SPC_OFS_STAT, d, r);
      chk("done flag", 1'h1, d[0]);
      repeat (3) @(posedge clk_in);
      chk("irq cleared", 1'h0, irq);
      rd(`SPC_OFS_DATA, d, r);
      chk("master rx", a, d);
      chk("partner rx", tx, p_got);
      chk("select lead ns", 32'h0000_0050, lead);
    end
    wr(`SPC_OFS_MASK, 32'h0000_0002, r);
    m_sel <= 1'h0;
    wr(`SPC_OFS_CTRL, 32'h0000_1083, r);
    repeat (8) @(posedge clk_in);
    chk("fault irq", 1'h1, irq);
    rd(`SPC_OFS_STAT, d, r);
    chk("fault flag", 2'h2, d[1:0]);
    m_sel <= 1'h1;
    wr(`SPC_OFS_CTRL, 32'h0000_1001, r);
    a = 8'($random(seed));
    tx = 8'($random(seed));
    wr(`SPC_OFS_DATA, {24'h0, a}, r);
    m_sel <= 1'h0;
    repeat (6) @(posedge clk_in);
    chk("slave drives", 1'h1, mi_oe);
    chk("slave first bit", a[7], mi_o);
    slv(tx, 1'h0, g);
    m_sel <= 1'h1;
    chk("slave reply", a, g);
    repeat (8) @(posedge clk_in);
    rd(`SPC_OFS_DATA, d, r);
    chk("slave rx", tx, d);
    wr(`SPC_OFS_CTRL, 32'h0000_1009, r);
    wr(`SPC_OFS_DATA, {24'h0, a}, r);
    m_sel <= 1'h0;
    slv(tx, 1'h1, g);
    slv(~tx, 1'h1, g2);
    m_sel <= 1'h1;
    chk("phase1 reply", a, g);
    chk("back to back reply", a, g2);
    repeat (8) @(posedge clk_in);
    rd(`SPC_OFS_DATA, d, r);
    chk("back to back rx", 8'(~tx), d);
    conclude();
  end

  initial begin : watchdog
    #300000;
    n_fail++;
    conclude();
  end
endmodule : spc_pin_control_and_framing_test

// [verification/spc_slave_model.sv]
// Purpose: Behavioural external slave that faces the block when it is master.
// Assumes: It is selected only by the select output that the block drives.
// Notes: It drives master-in only while selected; the bench pulls the line up otherwise.
module spc_slave_model (
  input  wire logic       sck_in,
  input  wire logic       sel_n_in,
  input  wire logic       cpha_in,
  input  wire logic       lsb_in,
  input  wire logic       mosi_in,
  input  wire logic [7:0] reply_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  output logic [7:0]      got_out,
  output int              lead_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt;
  int   k;
  time  t_sel;
  logic sel_act = 1'b0;

  function automatic logic pick(input int i);
    return lsb_in ? reply_in[i] : reply_in[7-i];
  endfunction : pick

  assign miso_oe_out = !sel_n_in;
  always @(negedge sel_n_in) begin
    sel_act = 1'b1;
    cnt = 0;
    k = 0;
    t_sel = $time;
    // In phase 1 the data is undefined before the first edge, so show the wrong bit.
    miso_out = cpha_in ? !pick(0) : pick(0);
  end
  // The select rises in the same step as the last clock edge, so the frame closes a little later.
  always @(posedge sel_n_in) begin
    #1 sel_act = 1'b0;
  end
  always @(sck_in) begin
    if (sel_act) begin
      cnt++;
      if (cnt == 1) lead_out = int'($time - t_sel);
      if (cnt[0] != cpha_in) begin
        got_out = lsb_in ? {mosi_in, got_out[7:1]} : {got_out[6:0], mosi_in};
      end else begin
        if (cnt > 1 && k < 7) k++;
        miso_out = pick(k);
      end
    end
  end
endmodule : spc_slave_model
